// File: src/tlf_pkg.sv
package tlf_pkg;
  localparam logic [7:0] ADDR_OVERTEMP_TIMER = 8'h79;
  localparam logic [7:0] ADDR_OVERTEMP_SIGNAL_DURATION_LIMIT = 8'h7A;
  localparam logic [7:0] ADDR_TACH_PULSE_COUNT_CONFIG = 8'h7B;
  localparam logic [7:0] ADDR_CONFIG_FOUR_PIN_THRESHOLD = 8'h7D;
  localparam logic [7:0] ADDR_MAKER_TEST_ONE = 8'h7E;
  localparam logic [7:0] ADDR_MAKER_TEST_TWO = 8'h7F;

  localparam logic [7:0] RST_OVERTEMP_SIGNAL_DURATION_LIMIT = 8'h00;
  localparam logic [7:0] RST_TACH_PULSE_COUNT_CONFIG = 8'h55;
  localparam logic [7:0] RST_CONFIG_FOUR_PIN_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_MAKER_TEST = 8'h00;

  localparam int unsigned ALERT_SEL_BIT = 0;
  localparam int unsigned RESERVED_RO_BIT = 1;
  localparam int unsigned THRESH_LSB = 2;
  localparam int unsigned THRESH_MSB = 3;
  localparam logic [7:0] CFG4_WRITE_MASK = 8'h0D;
  localparam int unsigned FAN_COUNT = 4;
  localparam int unsigned FAN_SEL_W = 2;

  localparam int unsigned STEP_TIME_NS = 22_760_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned STEP_CYC = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned STEP_CNT_W = 21;
  localparam logic [7:0] TIMER_MAX = 8'hFF;
endpackage : tlf_pkg

// File: src/tlf_regs.sv
module tlf_regs #(
  parameter int unsigned STEP_CYCLES = tlf_pkg::STEP_CYC
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  input wire logic config_lock_i,
  input wire logic overtemp_signal_i,
  input wire logic fourth_speed_input_is_overtemp_i,
  input wire logic timer_event_mask_i,
  input wire logic fault_flag_clear_i,
  output logic fourth_fan_or_timer_fault_flag_o,
  output logic timer_alert_o,
  output logic [7:0] overtemp_assert_timer_o,
  output logic [7:0] overtemp_signal_duration_limit_field_o,
  output logic [1:0] first_tach_pulse_select_o,
  output logic [1:0] second_tach_pulse_select_o,
  output logic [1:0] third_tach_pulse_select_o,
  output logic [1:0] fourth_tach_pulse_select_o,
  output logic [2:0] pulses_counted_o [tlf_pkg::FAN_COUNT],
  output logic alert_pin_function_select_o,
  output logic [1:0] two_wire_tach_threshold_o
);
  import tlf_pkg::*;

  logic [7:0] limit_q;
  logic [7:0] ppr_q;
  logic [7:0] cfg4_q;
  logic [7:0] rdata_q;
  logic [STEP_CNT_W-1:0] cyc_q;
  logic [7:0] units_q;
  logic asrt_q;
  logic ot_prev_q;
  logic flag_q;
  logic ot_rise;
  logic step_done;
  logic exceed;
  logic timer_rd;
  logic [7:0] timer_view;

  assign ot_rise = overtemp_signal_i && !ot_prev_q;
  assign step_done = overtemp_signal_i && !ot_rise &&
                     (cyc_q == STEP_CNT_W'(STEP_CYCLES - 1));
  assign exceed = overtemp_signal_i && !ot_rise && (units_q > limit_q);
  assign timer_rd = rd_en_i && (addr_i == ADDR_OVERTEMP_TIMER);
  assign timer_view = {units_q[7:1], units_q[0] | asrt_q};

  // Limit register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      limit_q <= RST_OVERTEMP_SIGNAL_DURATION_LIMIT;
    end else if (wr_en_i && addr_i == ADDR_OVERTEMP_SIGNAL_DURATION_LIMIT) begin
      limit_q <= wdata_i;
    end
  end

  // Pulse-count register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ppr_q <= RST_TACH_PULSE_COUNT_CONFIG;
    end else if (wr_en_i && addr_i == ADDR_TACH_PULSE_COUNT_CONFIG) begin
      ppr_q <= wdata_i;
    end
  end

  // Lockable fourth configuration register
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg4_q <= RST_CONFIG_FOUR_PIN_THRESHOLD;
    end else if (wr_en_i && addr_i == ADDR_CONFIG_FOUR_PIN_THRESHOLD && !config_lock_i) begin
      cfg4_q <= wdata_i & CFG4_WRITE_MASK;
    end
  end

  // Step counter within one 22.76 ms unit
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_q <= '0;
    end else if (!overtemp_signal_i || ot_rise || step_done) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + STEP_CNT_W'(1);
    end
  end

  // Assertion time in units, restarted on each new assertion
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      units_q <= '0;
    end else if (ot_rise) begin
      units_q <= '0;
    end else if (step_done && units_q != TIMER_MAX) begin
      units_q <= units_q + 8'h01;
    end
  end

  // Assertion seen flag, cleared by reading the timer, set wins
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      asrt_q <= 1'b0;
    end else if (ot_rise) begin
      asrt_q <= 1'b1;
    end else if (timer_rd) begin
      asrt_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ot_prev_q <= 1'b0;
    end else begin
      ot_prev_q <= overtemp_signal_i;
    end
  end

  // Sticky fault flag, set wins over clear
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_q <= 1'b0;
    end else if ((ot_rise && limit_q == 8'h00) || exceed) begin
      flag_q <= 1'b1;
    end else if (fault_flag_clear_i) begin
      flag_q <= 1'b0;
    end
  end

  // Read data
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 8'h00;
    end else if (rd_en_i) begin
      case (addr_i)
        ADDR_OVERTEMP_TIMER: rdata_q <= timer_view;
        ADDR_OVERTEMP_SIGNAL_DURATION_LIMIT: rdata_q <= limit_q;
        ADDR_TACH_PULSE_COUNT_CONFIG: rdata_q <= ppr_q;
        ADDR_CONFIG_FOUR_PIN_THRESHOLD: rdata_q <= cfg4_q;
        ADDR_MAKER_TEST_ONE: rdata_q <= RST_MAKER_TEST;
        ADDR_MAKER_TEST_TWO: rdata_q <= RST_MAKER_TEST;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign fourth_fan_or_timer_fault_flag_o = flag_q;
  assign timer_alert_o = flag_q && fourth_speed_input_is_overtemp_i &&
                         !timer_event_mask_i;
  assign overtemp_assert_timer_o = timer_view;
  assign overtemp_signal_duration_limit_field_o = limit_q;
  assign first_tach_pulse_select_o = ppr_q[1:0];
  assign second_tach_pulse_select_o = ppr_q[3:2];
  assign third_tach_pulse_select_o = ppr_q[5:4];
  assign fourth_tach_pulse_select_o = ppr_q[7:6];
  assign alert_pin_function_select_o = cfg4_q[ALERT_SEL_BIT];
  assign two_wire_tach_threshold_o = cfg4_q[THRESH_MSB:THRESH_LSB];

  // Pulses counted per fan: code plus one
  for (genvar f = 0; f < FAN_COUNT; f++) begin : g_fan
    assign pulses_counted_o[f] = {1'b0, ppr_q[FAN_SEL_W*f +: FAN_SEL_W]} + 3'd1;
  end

  sequence s_locked_cfg4_write;
    wr_en_i && config_lock_i && addr_i == ADDR_CONFIG_FOUR_PIN_THRESHOLD;
  endsequence

  sequence s_held_over_limit;
    overtemp_signal_i && ot_prev_q && units_q > limit_q;
  endsequence

  a_lock_blocks_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_locked_cfg4_write |=> $stable(cfg4_q))
    else $error("Locked configuration register changed");

  a_exceed_sets_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_held_over_limit |=> fourth_fan_or_timer_fault_flag_o ##1
      (fourth_fan_or_timer_fault_flag_o || $past(fault_flag_clear_i)))
    else $error("Fault flag not set after limit exceeded");

  a_zero_limit_now: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(overtemp_signal_i) && limit_q == 8'h00 |=> fourth_fan_or_timer_fault_flag_o)
    else $error("Zero limit did not raise flag at once");

  a_no_flag_at_limit: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !fourth_fan_or_timer_fault_flag_o && overtemp_signal_i && ot_prev_q && units_q <= limit_q
      |=> !fourth_fan_or_timer_fault_flag_o)
    else $error("Flag set without strict excess");

  a_pulse_reg_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_en_i && addr_i == ADDR_TACH_PULSE_COUNT_CONFIG
      |=> pulses_counted_o[3] == {1'b0, $past(wdata_i[7:6])} + 3'd1)
    else $error("Fourth fan pulse count wrong");

  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    cfg4_q[7:4] == 4'h0 && !cfg4_q[RESERVED_RO_BIT])
    else $error("Reserved configuration bits not zero");

  a_test_reads_zero: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rd_en_i && (addr_i == ADDR_MAKER_TEST_ONE || addr_i == ADDR_MAKER_TEST_TWO)
      |=> rdata_o == 8'h00)
    else $error("Test register read not zero");

  a_timer_steps: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    step_done && units_q != TIMER_MAX |=> units_q == $past(units_q) + 8'h01)
    else $error("Timer did not advance one unit");

  a_alert_masked: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    timer_event_mask_i || !fourth_speed_input_is_overtemp_i |-> !timer_alert_o)
    else $error("Masked timer event reached alert");

  a_alert_follows_cfg: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_en_i && !config_lock_i && addr_i == ADDR_CONFIG_FOUR_PIN_THRESHOLD
      |=> alert_pin_function_select_o == $past(wdata_i[0])
        && two_wire_tach_threshold_o == $past(wdata_i[3:2]))
    else $error("Alert select or threshold not written");

  a_pulse_reset_value: assert property (@(posedge core_clk_i)
    $rose(rstn_i) |-> ppr_q == RST_TACH_PULSE_COUNT_CONFIG)
    else $error("Pulse count register reset value wrong");

  // Fault flag and timer checks
  sequence s_overtemp_rise;
    overtemp_signal_i && !ot_prev_q;
  endsequence

  sequence s_set_with_clear;
    fault_flag_clear_i && ((overtemp_signal_i && !ot_prev_q && limit_q == 8'h00) ||
      (overtemp_signal_i && ot_prev_q && units_q > limit_q));
  endsequence

  a_set_beats_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_set_with_clear |=> fourth_fan_or_timer_fault_flag_o)
    else $error("Flag clear overrode a set event");

  a_clear_drops_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    fault_flag_clear_i && !(overtemp_signal_i && ot_prev_q && units_q > limit_q)
      && !(overtemp_signal_i && !ot_prev_q && limit_q == 8'h00)
      |=> !fourth_fan_or_timer_fault_flag_o)
    else $error("Fault flag not cleared");

  a_flag_stays_set: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    fourth_fan_or_timer_fault_flag_o && !fault_flag_clear_i
      |=> fourth_fan_or_timer_fault_flag_o)
    else $error("Fault flag dropped without clear");

  a_timer_restarts: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    s_overtemp_rise |=> overtemp_assert_timer_o == 8'h01)
    else $error("Timer not restarted on new assertion");

  a_timer_saturates: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    units_q == TIMER_MAX && !(overtemp_signal_i && !ot_prev_q) |=> units_q == TIMER_MAX)
    else $error("Timer wrapped past its maximum");

  a_timer_idle_hold: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !overtemp_signal_i |=> $stable(units_q))
    else $error("Timer moved while input idle");

  a_read_clears_seen: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    timer_rd && !(overtemp_signal_i && !ot_prev_q) |=> !asrt_q)
    else $error("Timer read did not clear assertion bit");

  a_alert_needs_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    timer_alert_o |-> fourth_fan_or_timer_fault_flag_o && fourth_speed_input_is_overtemp_i)
    else $error("Alert raised without flag");

  // Register port checks
  a_limit_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_en_i && addr_i == ADDR_OVERTEMP_SIGNAL_DURATION_LIMIT
      |=> overtemp_signal_duration_limit_field_o == $past(wdata_i))
    else $error("Limit register not written");

  a_limit_holds: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !(wr_en_i && addr_i == ADDR_OVERTEMP_SIGNAL_DURATION_LIMIT)
      |=> $stable(overtemp_signal_duration_limit_field_o))
    else $error("Limit register changed without write");

  a_limit_read_back: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rd_en_i && addr_i == ADDR_OVERTEMP_SIGNAL_DURATION_LIMIT |=> rdata_o == $past(limit_q))
    else $error("Limit register read back wrong");

  a_pulse_first_fan: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_en_i && addr_i == ADDR_TACH_PULSE_COUNT_CONFIG
      |=> pulses_counted_o[0] == {1'b0, $past(wdata_i[1:0])} + 3'd1)
    else $error("First fan pulse count wrong");

  a_cfg_read_reserved: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    rd_en_i && addr_i == ADDR_CONFIG_FOUR_PIN_THRESHOLD
      |=> !rdata_o[RESERVED_RO_BIT] && rdata_o[7:4] == 4'h0)
    else $error("Reserved configuration bits read nonzero");

  a_limit_reset_value: assert property (@(posedge core_clk_i)
    $rose(rstn_i) |-> limit_q == RST_OVERTEMP_SIGNAL_DURATION_LIMIT)
    else $error("Limit register reset value wrong");
endmodule : tlf_regs

// File: tb/overtemp_signal_limit_fan_config_regs_tb_top.sv
module overtemp_signal_limit_fan_config_regs_tb_top;
  import tlf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [7:0] a; logic [7:0] d; logic lk; logic [7:0] e;} tlf_row_t;
  logic core_clk_i, rstn_i, wr_en, rd_en, lock, ot, t4, mask, clr, flag, alert, alsel;
  logic [7:0] addr, wdata, rdata, tmr, lim, rd_v;
  logic [1:0] p1, p2, p3, p4, thr;
  logic [2:0] pc [FAN_COUNT];
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  tlf_row_t rows [8] = '{'{8'h7a, 8'ha5, 1'b0, 8'ha5}, '{8'h7b, 8'he4, 1'b0, 8'he4},
    '{8'h7d, 8'hff, 1'b0, 8'h0d}, '{8'h7d, 8'h08, 1'b0, 8'h08}, '{8'h7d, 8'h00, 1'b1, 8'h08},
    '{8'h7e, 8'hff, 1'b0, 8'h00}, '{8'h7f, 8'hff, 1'b0, 8'h00}, '{8'h7c, 8'hff, 1'b0, 8'h00}};

  tlf_regs #(.STEP_CYCLES(4)) tlf_regs_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .wr_en_i(wr_en), .rd_en_i(rd_en), .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata),
    .config_lock_i(lock), .overtemp_signal_i(ot), .fourth_speed_input_is_overtemp_i(t4),
    .timer_event_mask_i(mask), .fault_flag_clear_i(clr),
    .fourth_fan_or_timer_fault_flag_o(flag), .timer_alert_o(alert),
    .overtemp_assert_timer_o(tmr), .overtemp_signal_duration_limit_field_o(lim),
    .first_tach_pulse_select_o(p1), .second_tach_pulse_select_o(p2),
    .third_tach_pulse_select_o(p3), .fourth_tach_pulse_select_o(p4), .pulses_counted_o(pc),
    .alert_pin_function_select_o(alsel), .two_wire_tach_threshold_o(thr));
  tlf_host_model tlf_host_model_i (.core_clk_i(core_clk_i), .rdata_i(rdata), .wr_en_o(wr_en),
    .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata));

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    {rstn_i, lock, ot, t4, mask, clr} = 6'h00;
    repeat (3) @(negedge core_clk_i);
    rstn_i = 1'b1;
    foreach (rows[i]) begin
      lock = rows[i].lk;
      tlf_host_model_i.wr(rows[i].a, rows[i].d);
      tlf_host_model_i.rd(rows[i].a, rd_v);
      chk("register", rows[i].e, rd_v);
    end
    lock = 1'b0;
    for (int f = 0; f < 4; f++) chk("pulses", 8'(f + 1), {5'h00, pc[f]});
    chk("fields", 8'he4, {p4, p3, p2, p1});
    chk("alert select", 8'h00, {7'h00, alsel});
    chk("threshold", 8'h02, {6'h00, thr});
    chk("limit field", 8'ha5, lim);
    tlf_host_model_i.wr(8'h7d, 8'h0d);
    chk("alert select", 8'h01, {7'h00, alsel});
    chk("threshold", 8'h03, {6'h00, thr});
    rstn_i = 1'b0;
    @(negedge core_clk_i);
    rstn_i = 1'b1;
    tlf_host_model_i.rd(8'h7b, rd_v);
    chk("pulse reset", 8'h55, rd_v);
    tlf_host_model_i.rd(8'h7d, rd_v);
    chk("cfg reset", 8'h00, rd_v);
    chk("threshold reset", 8'h00, {6'h00, thr});
    chk("limit reset", 8'h00, lim);
    for (int f = 0; f < 4; f++) chk("pulse reset", 8'h02, {5'h00, pc[f]});
    t4 = 1'b1;
    tlf_host_model_i.wr(8'h7a, 8'h01);
    ot = 1'b1;
    repeat (6) @(negedge core_clk_i);
    chk("flag at limit", 8'h00, {7'h00, flag});
    repeat (6) @(negedge core_clk_i);
    chk("flag over limit", 8'h01, {7'h00, flag});
    chk("timer", 8'h03, tmr);
    chk("alert", 8'h01, {7'h00, alert});
    mask = 1'b1;
    ot = 1'b0;
    #1 chk("masked alert", 8'h00, {7'h00, alert});
    @(negedge core_clk_i);
    clr = 1'b1;
    @(negedge core_clk_i);
    clr = 1'b0;
    tlf_host_model_i.wr(8'h7a, 8'h00);
    chk("flag cleared", 8'h00, {7'h00, flag});
    tlf_host_model_i.rd(8'h79, rd_v);
    chk("timer read", 8'h03, rd_v);
    tlf_host_model_i.rd(8'h79, rd_v);
    chk("timer reread", 8'h02, rd_v);
    ot = 1'b1;
    repeat (2) @(negedge core_clk_i);
    chk("zero limit", 8'h01, {7'h00, flag});
    mask = 1'b0;
    #1 chk("unmasked alert", 8'h01, {7'h00, alert});
    t4 = 1'b0;
    #1 chk("tach pin alert", 8'h00, {7'h00, alert});
    clr = 1'b1;
    @(negedge core_clk_i);
    clr = 1'b0;
    chk("clear while held", 8'h00, {7'h00, flag});
    repeat (2) @(negedge core_clk_i);
    clr = 1'b1;
    @(negedge core_clk_i);
    clr = 1'b0;
    chk("set beats clear", 8'h01, {7'h00, flag});
    report_and_stop();
  end
endmodule : overtemp_signal_limit_fan_config_regs_tb_top

// File: tb/tlf_host_model.sv
module tlf_host_model (
  input wire logic core_clk_i,
  input wire logic [7:0] rdata_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // One-cycle write strobe, data released to its inverse afterwards
  // Test registers are never strobed, as host software should leave them alone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_en_o = (a != tlf_pkg::ADDR_MAKER_TEST_ONE) && (a != tlf_pkg::ADDR_MAKER_TEST_TWO);
    @(negedge core_clk_i);
    wr_en_o = 1'b0;
    wdata_o = ~d;
  endtask : wr
  // Read data is taken one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_i);
    addr_o = a;
    rd_en_o = 1'b1;
    @(negedge core_clk_i);
    rd_en_o = 1'b0;
    d = rdata_i;
  endtask : rd
endmodule : tlf_host_model
